// file: src/sts_pkg.sv
// Purpose: shared constants and types of the source transfer sequencer
// Assumes: 25 MHz system clock, AHB-Lite register access, word transfers
// Notes: all delays are programmed in milliseconds
package sts_pkg;

    // =========================================================
    // clocking and time base
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_NS = 1000000;
    // cycles per millisecond tick, derived from the clock period
    localparam int MS_TICK_CYC = MS_NS / CLK_PERIOD_NS;
    localparam int PRE_W = 24;
    localparam int DLY_W = 16;

    // =========================================================
    // register map (byte offsets, one word each)
    localparam int NUM_CFG = 6;
    localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
    localparam logic [31:0] OFS_ESD = 32'h0000_0004;
    localparam logic [31:0] OFS_NED = 32'h0000_0008;
    localparam logic [31:0] OFS_PTD = 32'h0000_000C;
    localparam logic [31:0] OFS_END = 32'h0000_0010;
    localparam logic [31:0] OFS_ECD = 32'h0000_0014;
    localparam logic [31:0] OFS_STATUS = 32'h0000_0018;
    localparam logic [2:0] IDX_CTRL = 3'h0;
    localparam logic [2:0] IDX_ESD = 3'h1;
    localparam logic [2:0] IDX_NED = 3'h2;
    localparam logic [2:0] IDX_PTD = 3'h3;
    localparam logic [2:0] IDX_END = 3'h4;
    localparam logic [2:0] IDX_ECD = 3'h5;
    localparam logic [2:0] IDX_STATUS = 3'h6;

    // reset values, indexed like the configuration words
    localparam logic [15:0] RST_VAL [NUM_CFG] = '{
        16'h0002, 16'h0BB8, 16'h2710, 16'h03E8, 16'h7530, 16'h7530
    };

    // =========================================================
    // control word fields
    localparam int CTL_CLOSED = 0;
    localparam int CTL_LEVEL2 = 1;
    localparam int CTL_APP_LO = 2;
    localparam int CTL_PRIME = 4;
    localparam int CTL_SHED = 5;
    localparam int CTL_EXER = 6;

    // status word fields
    localparam int STA_STATE_LO = 0;
    localparam int STA_IND_LO = 16;
    localparam int STA_GEN = 20;
    localparam int STA_CFG_ERR = 21;

    // application codes
    localparam logic [1:0] APP_U2G = 2'h0;
    localparam logic [1:0] APP_U2U = 2'h1;
    localparam logic [1:0] APP_G2G = 2'h2;

    // AHB transfer type bit that marks NONSEQ or SEQ
    localparam int HTRANS_ACT = 1;

    // sequencer states, one-hot
    typedef enum logic [9:0] {
        ST_ON_S1 = 10'h001,
        ST_ES_WAIT = 10'h002,
        ST_GEN_WAIT = 10'h004,
        ST_NE_WAIT = 10'h008,
        ST_NEUT_TX = 10'h010,
        ST_ON_S2 = 10'h020,
        ST_EN_WAIT = 10'h040,
        ST_NEUT_RT = 10'h080,
        ST_BOTH = 10'h100,
        ST_COOL = 10'h200
    } sts_state_t;

endpackage

// file: src/sts_delay.sv
// Purpose: millisecond down-counter shared by all sequence delays
// Assumes: load is a one-cycle request; value in milliseconds
// Notes: expired is a level, high from the cycle after a zero load
`timescale 1ns/10ps
`default_nettype none
module sts_delay
    import sts_pkg::*;
#(
    parameter int TICK_CYCLES = MS_TICK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic load_i,
    input wire logic [DLY_W-1:0] val_i,
    output logic expired_o
);

    // =========================================================
    // counter state
    logic [PRE_W-1:0] pre;
    logic [PRE_W-1:0] next_pre;
    logic [DLY_W-1:0] ms;
    logic [DLY_W-1:0] next_ms;
    logic armed;
    logic next_armed;
    logic tick;

    // prescaler wraps once per millisecond
    assign tick = (pre == PRE_W'(TICK_CYCLES - 1));

    // reload restarts the prescaler so a delay never runs short
    always_comb begin
        next_pre = tick ? '0 : pre + PRE_W'(1);
        next_ms = ms;
        next_armed = armed;
        if (load_i) begin
            next_pre = '0;
            next_ms = val_i;
            next_armed = 1'b1;
        end else if (tick && ms != '0) begin
            next_ms = ms - DLY_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre <= '0;
            ms <= '0;
            armed <= 1'b0;
        end else begin
            pre <= next_pre;
            ms <= next_ms;
            armed <= next_armed;
        end
    end

    assign expired_o = armed && (ms == '0);

endmodule
`default_nettype wire

// file: src/sts_ahb_regs.sv
// Purpose: AHB-Lite slave holding the configuration and status words
// Assumes: single word transfers; no wait states
// Notes: unmapped reads return zero, unmapped writes are dropped
`timescale 1ns/10ps
`default_nettype none
module sts_ahb_regs
    import sts_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] status_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [15:0] cfg_o [NUM_CFG]
);

    // =========================================================
    // address phase capture
    logic wr_pend;
    logic next_wr_pend;
    logic [2:0] wr_idx;
    logic [2:0] next_wr_idx;
    logic [31:0] next_rdata;
    logic [15:0] cfg [NUM_CFG];
    logic [15:0] next_cfg [NUM_CFG];
    logic acc;
    logic [2:0] a_idx;

    // size is not checked: only whole words are issued
    assign acc = hsel_i && htrans_i[HTRANS_ACT] && hready_i;
    assign a_idx = (haddr_i[31:5] == '0) ? haddr_i[4:2] : 3'h7;

    // writes land in the data phase, reads see the freshest words
    always_comb begin
        next_cfg = cfg;
        if (wr_pend && wr_idx < 3'(NUM_CFG)) begin
            next_cfg[wr_idx] = hwdata_i[15:0];
        end
        next_wr_pend = acc && hwrite_i;
        next_wr_idx = acc ? a_idx : wr_idx;
        next_rdata = hrdata_o;
        if (acc && !hwrite_i) begin
            if (a_idx < 3'(NUM_CFG)) begin
                next_rdata = {16'h0000, next_cfg[a_idx]};
            end else if (a_idx == IDX_STATUS) begin
                next_rdata = status_i;
            end else begin
                next_rdata = 32'h0000_0000;
            end
        end
    end

    // configuration words, one flop group per entry
    for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                cfg[i] <= RST_VAL[i];
            end else begin
                cfg[i] <= next_cfg[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_pend <= 1'b0;
            wr_idx <= 3'h0;
            hrdata_o <= 32'h0000_0000;
        end else begin
            wr_pend <= next_wr_pend;
            wr_idx <= next_wr_idx;
            hrdata_o <= next_rdata;
        end
    end

    assign cfg_o = cfg;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

endmodule
`default_nettype wire

// file: src/sts_top.sv
// Purpose: source transfer sequencer between a primary and a backup source
// Assumes: source sense, pickup and phase inputs are synchronous levels
// Notes: delays come from the register file in milliseconds
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - primary lost: start engine start delay, drop primary available lamp.
// - engine start delay expired, primary still bad: command generator start.
// - backup at pickup: light its available lamp, start normal to emergency delay.
// - normal to emergency delay done: switch to neutral, primary connected off.
// - hold neutral for programmed transition delay, then connect backup.
// - primary returns: light its lamp, start emergency to normal delay.
// - open retransfer: after that delay go neutral, backup connected lamp off.
// - retransfer holds neutral for programmed delay, then connects primary.
// - after retransfer run cooldown delay, then stop generator, lamp off.
// - open variant never connects both sources together.
// - closed variant parallels only when in phase, under 0.1 second.
// - utility to genset: start before transfer, stop after retransfer.
// - utility to utility: no generator control, no load shed, open only.
// - genset to genset: failed generator causes the other to start and connect.
// - genset to genset disables exerciser and load shedding.
// - genset to genset supports prime power and dual standby configurations.
// - closed variant needs higher level; basic level allows utility to genset only.
// - closed retransfer closes primary first, opens backup within 100 ms.
// - closed variant falls back to open transfer when sources not in sync.
module sts_top
    import sts_pkg::*;
#(
    parameter int TICK_CYCLES = MS_TICK_CYC
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_B_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic S1_OK_I,
    input wire logic S2_OK_I,
    input wire logic SYNC_I,
    output logic GEN_RUN_O,
    output logic GEN_A_RUN_O,
    output logic SW_S1_CLOSE_O,
    output logic SW_S2_CLOSE_O,
    output logic S1_AVAIL_O,
    output logic S2_AVAIL_O,
    output logic S1_CONN_O,
    output logic S2_CONN_O,
    output logic LOAD_SHED_EN_O,
    output logic EXERCISE_EN_O
);

    // =========================================================
    // registers and configuration decode
    logic [15:0] cfg [NUM_CFG];
    logic [31:0] status;
    logic [15:0] ctrl;
    logic [1:0] app;
    logic cfg_err;
    logic [1:0] app_eff;
    logic closed_eff;
    logic no_gen;

    sts_ahb_regs u_regs (
        .clk_i(SYS_CLK_I),
        .rst_b_i(RST_B_I),
        .hsel_i(HSEL_I),
        .haddr_i(HADDR_I),
        .htrans_i(HTRANS_I),
        .hwrite_i(HWRITE_I),
        .hsize_i(HSIZE_I),
        .hwdata_i(HWDATA_I),
        .hready_i(HREADY_I),
        .status_i(status),
        .hrdata_o(HRDATA_O),
        .hreadyout_o(HREADYOUT_O),
        .hresp_o(HRESP_O),
        .cfg_o(cfg)
    );

    assign ctrl = cfg[IDX_CTRL];
    assign app = ctrl[CTL_APP_LO +: 2];
    // level checks
    // an illegal mix falls back to plain open utility to genset
    assign cfg_err = (ctrl[CTL_CLOSED] && !ctrl[CTL_LEVEL2])
        || (!ctrl[CTL_LEVEL2] && app != APP_U2G)
        || (ctrl[CTL_CLOSED] && app != APP_U2G)
        || (app == 2'h3);
    assign app_eff = cfg_err ? APP_U2G : app;
    assign closed_eff = ctrl[CTL_CLOSED] && !cfg_err;
    assign no_gen = (app_eff == APP_U2U);

    // =========================================================
    // sequencer state
    sts_state_t state;
    sts_state_t next_state;
    logic gen_run;
    logic next_gen_run;
    logic sw1;
    logic next_sw1;
    logic sw2;
    logic next_sw2;
    logic s1_av;
    logic next_s1_av;
    logic s2_av;
    logic next_s2_av;
    logic shed;
    logic next_shed;
    logic exer;
    logic next_exer;
    logic gen_a;
    logic next_gen_a;
    logic tmr_load;
    logic [DLY_W-1:0] tmr_val;
    logic tmr_done;
    logic par_ok;

    sts_delay #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_delay (
        .clk_i(SYS_CLK_I),
        .rst_b_i(RST_B_I),
        .load_i(tmr_load),
        .val_i(tmr_val),
        .expired_o(tmr_done)
    );

    // paralleling allowed only on live in-phase sources
    assign par_ok = closed_eff && SYNC_I && S1_OK_I && S2_OK_I;

    // transfer sequence; the delay is reloaded on every state change
    always_comb begin
        next_state = state;
        next_gen_run = gen_run;
        unique case (state)
            ST_ON_S1: begin
                if (!S1_OK_I) begin
                    next_state = no_gen ? ST_GEN_WAIT : ST_ES_WAIT;
                end
            end
            ST_ES_WAIT: begin
                if (S1_OK_I) begin
                    next_state = ST_ON_S1;
                end else if (tmr_done) begin
                    next_state = ST_GEN_WAIT;
                    next_gen_run = 1'b1;
                end
            end
            ST_GEN_WAIT: begin
                if (S1_OK_I) begin
                    next_state = no_gen ? ST_ON_S1 : ST_COOL;
                end else if (S2_OK_I) begin
                    next_state = ST_NE_WAIT;
                end
            end
            ST_NE_WAIT: begin
                if (S1_OK_I) begin
                    next_state = no_gen ? ST_ON_S1 : ST_COOL;
                end else if (tmr_done) begin
                    next_state = ST_NEUT_TX;
                end
            end
            ST_NEUT_TX: begin
                if (tmr_done) begin
                    next_state = ST_ON_S2;
                end
            end
            ST_ON_S2: begin
                if (S1_OK_I) begin
                    next_state = ST_EN_WAIT;
                end
            end
            ST_EN_WAIT: begin
                if (!S1_OK_I) begin
                    next_state = ST_ON_S2;
                end else if (tmr_done && par_ok) begin
                    next_state = ST_BOTH;
                end else if (tmr_done) begin
                    next_state = ST_NEUT_RT;
                end
            end
            ST_NEUT_RT: begin
                if (tmr_done) begin
                    next_state = no_gen ? ST_ON_S1 : ST_COOL;
                end
            end
            ST_BOTH: begin
                // overlap held a single clock, far inside the limit
                next_state = ST_COOL;
            end
            ST_COOL: begin
                // primary lost again while the engine still runs
                if (!S1_OK_I && S2_OK_I) begin
                    next_state = ST_NE_WAIT;
                end else if (!S1_OK_I) begin
                    next_state = ST_GEN_WAIT;
                end else if (tmr_done) begin
                    next_state = ST_ON_S1;
                    next_gen_run = 1'b0;
                end
            end
            default: begin
                next_state = ST_ON_S1;
            end
        endcase
        if (no_gen) begin
            next_gen_run = 1'b0;
        end
    end

    // delay reload picks the value for the state being entered
    always_comb begin
        tmr_load = (next_state != state);
        unique case (next_state)
            ST_ES_WAIT: tmr_val = cfg[IDX_ESD];
            ST_NE_WAIT: tmr_val = cfg[IDX_NED];
            ST_NEUT_TX, ST_NEUT_RT: tmr_val = cfg[IDX_PTD];
            ST_EN_WAIT: tmr_val = cfg[IDX_END];
            ST_COOL: tmr_val = cfg[IDX_ECD];
            default: tmr_val = '0;
        endcase
    end

    // contacts follow the state being entered, available lamps follow the source inputs
    always_comb begin
        next_sw1 = (next_state & (ST_ON_S1 | ST_ES_WAIT | ST_GEN_WAIT | ST_NE_WAIT
            | ST_BOTH | ST_COOL)) != '0;
        next_sw2 = (next_state & (ST_ON_S2 | ST_EN_WAIT | ST_BOTH)) != '0;
        next_s1_av = S1_OK_I;
        // backup lamp needs a running set, except in utility to utility
        next_s2_av = S2_OK_I && (next_gen_run || no_gen);
        next_shed = ctrl[CTL_SHED] && (app_eff == APP_U2G);
        next_exer = ctrl[CTL_EXER] && (app_eff != APP_G2G);
        // prime power keeps the first set running
        next_gen_a = (app_eff == APP_G2G) && ctrl[CTL_PRIME];
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state <= ST_ON_S1;
            gen_run <= 1'b0;
            sw1 <= 1'b1;
            sw2 <= 1'b0;
            s1_av <= 1'b0;
            s2_av <= 1'b0;
            shed <= 1'b0;
            exer <= 1'b0;
            gen_a <= 1'b0;
        end else begin
            state <= next_state;
            gen_run <= next_gen_run;
            sw1 <= next_sw1;
            sw2 <= next_sw2;
            s1_av <= next_s1_av;
            s2_av <= next_s2_av;
            shed <= next_shed;
            exer <= next_exer;
            gen_a <= next_gen_a;
        end
    end

    // =========================================================
    // outputs and status word
    assign GEN_RUN_O = gen_run;
    assign GEN_A_RUN_O = gen_a;
    assign SW_S1_CLOSE_O = sw1;
    assign SW_S2_CLOSE_O = sw2;
    assign S1_CONN_O = sw1;
    assign S2_CONN_O = sw2;
    assign S1_AVAIL_O = s1_av;
    assign S2_AVAIL_O = s2_av;
    assign LOAD_SHED_EN_O = shed;
    assign EXERCISE_EN_O = exer;
    assign status = {10'h000, cfg_err, gen_run, s2_av, s1_av, sw2, sw1, 6'h00, state};

    // =========================================================
    // checks
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_B_I);

    sequence s_closed_entry;
        state == ST_EN_WAIT && S1_OK_I && tmr_done && par_ok;
    endsequence

    sequence s_both_then_s1;
        (sw1 && sw2) ##1 (sw1 && !sw2);
    endsequence

    s1_fail_timer_a: assert property (
        state == ST_ON_S1 && !S1_OK_I && !no_gen |=> state == ST_ES_WAIT && !S1_AVAIL_O)
        else $error("primary loss did not start the start delay");
    gen_start_a: assert property (
        state == ST_ES_WAIT && tmr_done && !S1_OK_I |=> GEN_RUN_O)
        else $error("generator not started after start delay");
    pickup_delay_a: assert property (
        state == ST_GEN_WAIT && S2_OK_I && !S1_OK_I |=> state == ST_NE_WAIT ##1 S2_AVAIL_O)
        else $error("pickup did not start transfer delay");
    ne_neutral_a: assert property (
        state == ST_NE_WAIT && tmr_done && !S1_OK_I |=> !SW_S1_CLOSE_O && !SW_S2_CLOSE_O)
        else $error("switch not neutral after transfer delay");
    tx_connect_a: assert property (
        state == ST_NEUT_TX && tmr_done |=> SW_S2_CLOSE_O && !SW_S1_CLOSE_O && S2_CONN_O)
        else $error("backup not connected after neutral hold");
    s1_return_a: assert property (
        state == ST_ON_S2 && S1_OK_I |=> state == ST_EN_WAIT && S1_AVAIL_O)
        else $error("primary return not seen");
    open_retx_a: assert property (
        state == ST_EN_WAIT && S1_OK_I && tmr_done && !par_ok |=> !SW_S2_CLOSE_O && !SW_S1_CLOSE_O)
        else $error("open retransfer did not go neutral");
    rt_connect_a: assert property (
        state == ST_NEUT_RT && tmr_done |=> SW_S1_CLOSE_O && !SW_S2_CLOSE_O)
        else $error("primary not connected after neutral hold");
    cool_stop_a: assert property (
        state == ST_COOL && S1_OK_I && tmr_done |=> !GEN_RUN_O && state == ST_ON_S1)
        else $error("generator not stopped after cooldown");
    no_parallel_a: assert property (
        !closed_eff |-> !(SW_S1_CLOSE_O && SW_S2_CLOSE_O))
        else $error("both sources connected in open mode");
    short_overlap_a: assert property (
        SW_S1_CLOSE_O && SW_S2_CLOSE_O |-> $past(par_ok) ##1 !SW_S2_CLOSE_O)
        else $error("parallel too long or not in phase");
    closed_order_a: assert property (
        s_closed_entry |=> s_both_then_s1)
        else $error("closed retransfer order wrong");
    u2u_nogen_a: assert property (
        no_gen |=> !GEN_RUN_O && !LOAD_SHED_EN_O)
        else $error("generator or shed active in utility pair mode");
    g2g_block_a: assert property (
        app_eff == APP_G2G |=> !EXERCISE_EN_O && !LOAD_SHED_EN_O)
        else $error("exerciser or shed active in genset pair mode");
    esd_cancel_a: assert property (
        state == ST_ES_WAIT && S1_OK_I && !GEN_RUN_O |=> state == ST_ON_S1 && !GEN_RUN_O)
        else $error("start delay not cancelled");

endmodule
`default_nettype wire

// file: verification/sts_gen_model.sv
// Purpose: backup source model, a generator set or a second utility
// Assumes: run command is a level from the sequencer
// Notes: a stopped set gives no pickup at once
`timescale 1ns/10ps
`default_nettype none
module sts_gen_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    input wire logic mains_i,
    output logic ok_o
);
    // ==========================================
    // crank and run up time, counted in clocks
    logic [3:0] warm;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) warm <= 4'h0;
        else if (!run_i) warm <= 4'h0;
        else if (warm != 4'hF) warm <= warm + 4'h1;
    end
    // a second utility is live without any start
    assign ok_o = mains_i | (warm > 4'h5);
endmodule
`default_nettype wire

// file: verification/sts_top_tb.sv
// Purpose: sequence and register checks of the transfer sequencer
// Assumes: tick of 4 clocks per millisecond
// Notes: delays programmed to 1 or 2 ms to keep the run short
`timescale 1ns/10ps
`default_nettype none
module sts_top_tb;
    import sts_pkg::*;
    // ==========================================
    // stimulus and observation
    logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
    logic [1:0] htrans = 2'h0;
    logic s1_ok = 1'b1, sync = 1'b0, mains = 1'b0, par_ok = 1'b0, saw_both = 1'b0;
    wire [31:0] hrdata;
    wire hready, hresp, s2_ok, gen_run, gen_a, sw1, sw2, av1, av2, cn1, cn2, shed, exer;
    wire [9:0] obs = {exer, shed, cn2, cn1, av2, av1, sw2, sw1, gen_a, gen_run};
    int err_total = 0, checks_done = 0, both_run = 0;
    localparam logic [7:0] MODE [9] = '{8'h22, 8'h62, 8'h66, 8'h6A, 8'h7A,
        8'h01, 8'h04, 8'h07, 8'h0E};
    localparam logic [3:0] MEXP [9] = '{4'h1, 4'h3, 4'h2, 4'h0, 4'h4,
        4'h8, 4'h8, 4'h8, 4'h8};
    always #20 clk = ~clk;
    sts_top #(.TICK_CYCLES(4)) sts_top_inst (.SYS_CLK_I(clk), .RST_B_I(rst_b),
        .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp), .S1_OK_I(s1_ok), .S2_OK_I(s2_ok),
        .SYNC_I(sync), .GEN_RUN_O(gen_run), .GEN_A_RUN_O(gen_a), .SW_S1_CLOSE_O(sw1),
        .SW_S2_CLOSE_O(sw2), .S1_AVAIL_O(av1), .S2_AVAIL_O(av2), .S1_CONN_O(cn1),
        .S2_CONN_O(cn2), .LOAD_SHED_EN_O(shed), .EXERCISE_EN_O(exer));
    sts_gen_model sts_gen_model_inst (.clk_i(clk), .rst_b_i(rst_b), .run_i(gen_run),
        .mains_i(mains), .ok_o(s2_ok));
    // ==========================================
    // compare, bus and wait tasks
    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk32(nm, {31'h0, e}, {31'h0, g});
    endtask
    // address phase held until hready, then data phase likewise
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk32(nm, e, q);
        chk1("hresp okay", 1'b0, hresp);
    endtask
    // bounded wait for one observed output to reach a level
    task automatic wait_on(input string nm, input int b, input logic v);
        int n;
        n = 0;
        while (obs[b] !== v && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk1(nm, v, obs[b]);
    endtask
    // one outage of the primary and its return
    task automatic outage(input logic sy, input logic u2u);
        @(posedge clk);
        s1_ok <= 1'b0;
        sync <= sy;
        wait_on("s1 avail off", 4, 1'b0);
        chk1("gen held", 1'b0, gen_run);
        wait_on("gen start", 0, !u2u);
        wait_on("s2 avail", 5, 1'b1);
        wait_on("s1 conn off", 6, 1'b0);
        chk1("neutral", 1'b0, sw2);
        wait_on("s2 conn", 7, 1'b1);
        chk1("gen run", !u2u, gen_run);
        @(posedge clk);
        s1_ok <= 1'b1;
        wait_on("s1 avail", 4, 1'b1);
        wait_on("s1 conn", 6, 1'b1);
        wait_on("s2 conn off", 7, 1'b0);
        wait_on("gen stop", 0, 1'b0);
        wait_on("s2 avail end", 5, u2u);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ==========================================
    // parallel watch: one clock at most, only when allowed
    always @(posedge clk) begin
        both_run <= (sw1 === 1'b1 && sw2 === 1'b1) ? both_run + 1 : 0;
        if (both_run > 0) saw_both <= 1'b1;
        if (both_run > (par_ok ? 1 : 0)) chk1("parallel", 1'b0, 1'b1);
    end
    // hang guard, well beyond the planned run
    initial begin
        #800000;
        err_total++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < NUM_CFG; i++) rd("reset val", i * 4, {16'h0, RST_VAL[i]});
        ahb(1'b1, 32'h40, 32'hFFFF);
        rd("unmapped", 32'h40, 32'h0);
        ahb(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
        rd("status", OFS_STATUS, 32'h0005_0001);
        for (int i = 1; i < NUM_CFG; i++) ahb(1'b1, i * 4, (i == 3) ? 32'h1 : 32'h2);
        rd("ptd back", OFS_PTD, 32'h1);
        outage(1'b0, 1'b0);
        // short dip inside the engine start delay
        s1_ok <= 1'b0;
        repeat (3) @(posedge clk);
        s1_ok <= 1'b1;
        repeat (30) @(posedge clk) chk1("dip gen", 1'b0, gen_run);
        chk1("dip avail", 1'b1, av1);
        ahb(1'b1, OFS_CTRL, 32'h3);
        par_ok <= 1'b1;
        outage(1'b1, 1'b0);
        chk1("closed overlap", 1'b1, saw_both);
        par_ok <= 1'b0;
        outage(1'b0, 1'b0);
        ahb(1'b1, OFS_CTRL, 32'h6);
        mains <= 1'b1;
        outage(1'b0, 1'b1);
        ahb(1'b1, OFS_CTRL, 32'hA);
        mains <= 1'b0;
        outage(1'b0, 1'b0);
        for (int m = 0; m < 9; m++) begin
            ahb(1'b1, OFS_CTRL, {24'h0, MODE[m]});
            repeat (3) @(posedge clk);
            chk1("shed", MEXP[m][0], shed);
            chk1("exer", MEXP[m][1], exer);
            chk1("gen a", MEXP[m][2], gen_a);
            ahb(1'b0, OFS_STATUS, 32'h0);
            chk1("cfg err", MEXP[m][3], q[STA_CFG_ERR]);
        end
        final_report();
    end
endmodule
`default_nettype wire
